// ===== include/ucm_pkg.sv
package ucm_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LVL_W = 12;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_HOLDOFF = 8'h0C;
	localparam logic [7:0] OFS_OFFSET = 8'h10;
	localparam logic [7:0] OFS_SCALE = 8'h14;
	localparam logic [7:0] OFS_SIG_COUNT = 8'h18;
	localparam logic [7:0] OFS_REF_COUNT = 8'h1C;
	localparam logic [7:0] OFS_RESULT = 8'h20;
	localparam logic [7:0] OFS_TRIG1 = 8'h24;
	localparam logic [7:0] OFS_TRIG2 = 8'h28;

	// Command register bit positions
	localparam int unsigned CMD_ARM_START = 0;
	localparam int unsigned CMD_ARM_STOP = 1;
	localparam int unsigned CMD_ABORT = 2;
	localparam int unsigned CMD_CLEAR = 3;
	localparam int unsigned CMD_MAN_START = 4;
	localparam int unsigned CMD_MAN_STOP = 5;

	// Trigger register field positions
	localparam int unsigned TRIG_AUTO_BIT = 16;
	localparam int unsigned TRIG_X10_BIT = 17;

	// Reset values
	localparam logic [22:0] CONFIG_RESET = 23'h000080;
	localparam logic [31:0] HOLDOFF_RESET = 32'h00000000;
	localparam logic [31:0] OFFSET_RESET = 32'h00000000;
	localparam logic [31:0] SCALE_RESET = 32'h00000001;

	// Counts
	localparam logic [6:0] AVG_COUNT = 7'h64;
	localparam logic [47:0] DEG_PER_CYCLE = 48'h168;
	localparam logic [5:0] DIV_STEPS = 6'h30;
	localparam logic [11:0] AC_MIN_SPAN = 12'h040;
	localparam logic signed [11:0] X1_LIMIT = 12'sh700;

	typedef enum logic [4:0] {
		UCM_FREQ1 = 5'h00, UCM_FREQ2 = 5'h01, UCM_PER1 = 5'h02, UCM_PER2 = 5'h03,
		UCM_TI12 = 5'h04, UCM_TI21 = 5'h05, UCM_TOT12 = 5'h06, UCM_TOT21 = 5'h07,
		UCM_MTOT1 = 5'h08, UCM_MTOT2 = 5'h09, UCM_RAT12 = 5'h0A, UCM_RAT32 = 5'h0B,
		UCM_CHECK = 5'h0C, UCM_PH12 = 5'h0D, UCM_PH21 = 5'h0E, UCM_PWP = 5'h0F,
		UCM_PWN = 5'h10
	} ucm_func_e;

	typedef enum logic [2:0] {
		UCM_IDLE = 3'h0, UCM_ARM_WAIT = 3'h1, UCM_START_WAIT = 3'h2,
		UCM_OPEN = 3'h3, UCM_STOP_WAIT = 3'h4, UCM_CALC = 3'h5
	} ucm_state_e;

	// Layout matches CONFIG register bits [22:0]
	typedef struct packed {
		logic gate_en;
		logic [2:0] gate_line;
		logic math_en;
		logic avg_en;
		logic [1:0] ref_sel;
		logic [3:0] ext_sel;
		logic [3:0] arm_mode;
		logic stop_slope;
		logic start_slope;
		ucm_func_e func;
	} ucm_cfg_s;

	typedef struct packed {
		logic x10;
		logic auto_en;
		logic [11:0] level;
	} ucm_trig_s;

endpackage : ucm_pkg

// ===== hw/ucm_measure.sv
// Overview of operation
// - Frequency and period of input 1 or 2, signal and reference counted over gate.
// - Time interval from start input event to stop input event, either order.
// - Stop arming may be held off after start for interval and totalize-by-input.
// - Totalize 1 by 2: start on input 2 slope edge, stop on opposite edge.
// - Totalize 2 by 1: start and stop both on same input 1 slope edge.
// - Manual totalize: commands open and close; count kept until clear command.
// - Ratio 1/2 and 3/2: input 1 or 3 and reference counted over one gate; input 2 not counted.
// - Check mode counts reference in both chains; result equals reference frequency.
// - Phase lead in degrees of selected input; signal must stay continuous.
// - Pulse width: rising to falling, or falling to rising, on input 1.
// - Math: reading equals result minus offset, divided by scale; defaults 0 and 1.
// - Averaging returns mean of 100 runs for frequency, period, ratio, interval.
// - Auto trigger sets level midway between peaks, or DC level if flat.
// - Auto trigger switches to X10 attenuation when level too high for X1.
// - Leaving auto takes the level written with it; the last auto level is not kept.
// - Start and stop edges each independently rising or falling for frequency, period, interval and ratio.
// - Nine arming modes: internal or external rising/falling for start and stop.
// - External arming for every function except phase; in manual totalize only the start can be armed.
// - External arm taken from one of eight trigger lines or front-panel input.
// - Internal stop hold-off delay programmable for interval measurements.
// - Reference chosen from backplane, external port or oscillator; drives output.
// - Gate pulse optionally driven onto one selected trigger line 0 to 7.
// - Armed start edge opens gate for both chains; armed stop edge closes.
// - Measurement events signalled by event output; controller reads chains.
`timescale 1ns/1ns
`default_nettype none

module ucm_measure #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [2:0] sig_in,
	input wire logic front_arm_in,
	input wire logic [7:0] ttl_in,
	output logic [7:0] ttl_out,
	output logic [7:0] ttl_oe,
	input wire logic ref_clk10_bp,
	input wire logic reference_input_port,
	input wire logic ref_osc_int,
	output logic reference_output_port,
	input wire logic [1:0][11:0] pk_max,
	input wire logic [1:0][11:0] pk_min,
	input wire logic [1:0][11:0] dc_level,
	output logic [1:0][11:0] trig_level,
	output logic [1:0] atten_x10,
	output logic meas_event,
	output logic gate_active
);

	if (CNT_W != 32) begin : g_chk
		$error("ucm_measure supports CNT_W of 32 only");
	end

	// Synchronisers: sig 0..2, ttl 3..10, front 11, refs 12..14
	logic [14:0] sync1;
	logic [14:0] sync2;
	logic [14:0] sync3;
	logic [14:0] rise;
	logic [14:0] fall;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync1 <= 15'h0000;
			sync2 <= 15'h0000;
			sync3 <= 15'h0000;
		end else if (ce) begin
			sync1 <= {ref_osc_int, reference_input_port, ref_clk10_bp, front_arm_in, ttl_in, sig_in};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign rise = sync2 & ~sync3;
	assign fall = ~sync2 & sync3;

	function automatic logic edge_of(input logic r, input logic f, input logic neg);
		return neg ? f : r;
	endfunction : edge_of

	// {start_ext, start_rise, stop_ext, stop_rise}
	function automatic logic [3:0] arm_decode(input logic [3:0] mode, input logic phase);
		logic [3:0] d;
		d = 4'h0;
		if (!phase) begin
			unique case (mode)
				4'h2: d = 4'hC;
				4'h3: d = 4'h8;
				4'h4: d = 4'h3;
				4'h5: d = 4'h2;
				4'h6: d = 4'hF;
				4'h7: d = 4'hE;
				4'h8: d = 4'hB;
				4'h9: d = 4'hA;
				default: d = 4'h0;
			endcase
		end
		return d;
	endfunction : arm_decode

	// Register file
	ucm_pkg::ucm_cfg_s cfg;
	ucm_pkg::ucm_cfg_s act;
	logic [31:0] holdoff;
	logic [31:0] offset;
	logic [31:0] scale;
	ucm_pkg::ucm_trig_s trig [2];
	logic [31:0] cmd;
	logic rd_result;

	assign cmd = (reg_wr && reg_addr == ucm_pkg::OFS_CMD) ? reg_wdata : 32'h00000000;
	assign rd_result = reg_rd && reg_addr == ucm_pkg::OFS_RESULT;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg <= ucm_pkg::CONFIG_RESET;
			holdoff <= ucm_pkg::HOLDOFF_RESET;
			offset <= ucm_pkg::OFFSET_RESET;
			scale <= ucm_pkg::SCALE_RESET;
		end else if (ce && reg_wr) begin
			unique case (reg_addr)
				ucm_pkg::OFS_CONFIG: cfg <= reg_wdata[22:0];
				ucm_pkg::OFS_HOLDOFF: holdoff <= reg_wdata;
				ucm_pkg::OFS_OFFSET: offset <= reg_wdata;
				ucm_pkg::OFS_SCALE: scale <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Trigger level: manual writes and continuous auto update share one register
	for (genvar c = 0; c < 2; c++) begin : g_trig
		logic signed [11:0] hi;
		logic signed [11:0] lo;
		logic [11:0] span;
		logic signed [12:0] mid_sum;
		logic wr_this;
		assign hi = pk_max[c];
		assign lo = pk_min[c];
		assign span = hi - lo;
		assign mid_sum = 13'(hi) + 13'(lo);
		assign wr_this = reg_wr && reg_addr == (c == 0 ? ucm_pkg::OFS_TRIG1 : ucm_pkg::OFS_TRIG2);

		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				trig[c] <= '0;
			end else if (ce) begin
				if (wr_this) begin
					trig[c].level <= reg_wdata[11:0];
					trig[c].auto_en <= reg_wdata[ucm_pkg::TRIG_AUTO_BIT];
					trig[c].x10 <= reg_wdata[ucm_pkg::TRIG_X10_BIT];
				end else if (trig[c].auto_en) begin
					if (span < ucm_pkg::AC_MIN_SPAN) begin
						trig[c].level <= dc_level[c];
					end else begin
						trig[c].level <= mid_sum[12:1];
					end
					if (hi > ucm_pkg::X1_LIMIT || lo < -ucm_pkg::X1_LIMIT) begin
						trig[c].x10 <= 1'b1;
					end
				end
			end
		end

		assign trig_level[c] = trig[c].level;
		assign atten_x10[c] = trig[c].x10;
	end

	// Measurement event decode from the captured configuration
	logic is_phase;
	logic is_manual;
	logic use_hold;
	logic [3:0] arm;
	logic ext_sig;
	logic ext_start_ev;
	logic ext_stop_ev;
	logic start_ev;
	logic stop_ev;
	logic cap_ev;
	logic sig_ev;
	logic ref_ev;
	logic ref_sync;
	logic primary_ref;
	logic avg_ok;

	assign is_phase = act.func inside {ucm_pkg::UCM_PH12, ucm_pkg::UCM_PH21};
	assign is_manual = act.func inside {ucm_pkg::UCM_MTOT1, ucm_pkg::UCM_MTOT2};
	assign use_hold = act.func inside {ucm_pkg::UCM_TI12, ucm_pkg::UCM_TI21,
		ucm_pkg::UCM_TOT12, ucm_pkg::UCM_TOT21};
	assign arm = arm_decode(act.arm_mode, is_phase);
	assign ext_sig = act.ext_sel[3] ? sync2[11] : sync2[3 + act.ext_sel[2:0]];
	assign ext_start_ev = act.ext_sel[3] ? edge_of(rise[11], fall[11], !arm[2])
		: edge_of(rise[3 + act.ext_sel[2:0]], fall[3 + act.ext_sel[2:0]], !arm[2]);
	assign ext_stop_ev = act.ext_sel[3] ? edge_of(rise[11], fall[11], !arm[0])
		: edge_of(rise[3 + act.ext_sel[2:0]], fall[3 + act.ext_sel[2:0]], !arm[0]);
	assign ref_ev = rise[12 + ((act.ref_sel == 2'h3) ? 2'h0 : act.ref_sel)];
	assign ref_sync = sync2[12 + ((act.ref_sel == 2'h3) ? 2'h0 : act.ref_sel)];

	always_comb begin
		start_ev = 1'b0;
		stop_ev = 1'b0;
		cap_ev = 1'b0;
		sig_ev = 1'b0;
		primary_ref = 1'b0;
		avg_ok = 1'b0;
		unique case (act.func)
			ucm_pkg::UCM_FREQ1, ucm_pkg::UCM_PER1, ucm_pkg::UCM_MTOT1: begin
				start_ev = edge_of(rise[0], fall[0], act.start_slope);
				stop_ev = edge_of(rise[0], fall[0], act.stop_slope);
				sig_ev = rise[0];
				primary_ref = act.func == ucm_pkg::UCM_PER1;
				avg_ok = !is_manual;
			end
			ucm_pkg::UCM_FREQ2, ucm_pkg::UCM_PER2, ucm_pkg::UCM_MTOT2: begin
				start_ev = edge_of(rise[1], fall[1], act.start_slope);
				stop_ev = edge_of(rise[1], fall[1], act.stop_slope);
				sig_ev = rise[1];
				primary_ref = act.func == ucm_pkg::UCM_PER2;
				avg_ok = !is_manual;
			end
			ucm_pkg::UCM_TI12, ucm_pkg::UCM_TI21: begin
				start_ev = act.func == ucm_pkg::UCM_TI12 ? edge_of(rise[0], fall[0], act.start_slope)
					: edge_of(rise[1], fall[1], act.start_slope);
				stop_ev = act.func == ucm_pkg::UCM_TI12 ? edge_of(rise[1], fall[1], act.stop_slope)
					: edge_of(rise[0], fall[0], act.stop_slope);
				primary_ref = 1'b1;
				avg_ok = 1'b1;
			end
			ucm_pkg::UCM_TOT12: begin
				start_ev = edge_of(rise[1], fall[1], act.start_slope);
				stop_ev = edge_of(rise[1], fall[1], !act.start_slope);
				sig_ev = rise[0];
			end
			ucm_pkg::UCM_TOT21: begin
				start_ev = edge_of(rise[0], fall[0], act.start_slope);
				stop_ev = edge_of(rise[0], fall[0], act.start_slope);
				sig_ev = rise[1];
			end
			ucm_pkg::UCM_RAT12, ucm_pkg::UCM_RAT32: begin
				start_ev = act.func == ucm_pkg::UCM_RAT12 ? edge_of(rise[0], fall[0], act.start_slope)
					: edge_of(rise[2], fall[2], act.start_slope);
				stop_ev = act.func == ucm_pkg::UCM_RAT12 ? edge_of(rise[0], fall[0], act.stop_slope)
					: edge_of(rise[2], fall[2], act.stop_slope);
				sig_ev = act.func == ucm_pkg::UCM_RAT12 ? rise[0] : rise[2];
				avg_ok = 1'b1;
			end
			ucm_pkg::UCM_CHECK: begin
				start_ev = ref_ev;
				stop_ev = ref_ev;
				sig_ev = ref_ev;
			end
			ucm_pkg::UCM_PH12, ucm_pkg::UCM_PH21: begin
				start_ev = act.func == ucm_pkg::UCM_PH12 ? edge_of(rise[0], fall[0], act.start_slope)
					: edge_of(rise[1], fall[1], act.start_slope);
				stop_ev = start_ev;
				cap_ev = act.func == ucm_pkg::UCM_PH12 ? edge_of(rise[1], fall[1], act.start_slope)
					: edge_of(rise[0], fall[0], act.start_slope);
			end
			ucm_pkg::UCM_PWP: begin
				start_ev = rise[0];
				stop_ev = fall[0];
				primary_ref = 1'b1;
			end
			ucm_pkg::UCM_PWN: begin
				start_ev = fall[0];
				stop_ev = rise[0];
				primary_ref = 1'b1;
			end
			default: ;
		endcase
	end

	// Sequential divider shared by phase, averaging and math
	logic div_start;
	logic [47:0] div_num;
	logic [31:0] div_den;
	logic div_busy;
	logic div_done;
	logic [5:0] div_cnt;
	logic [47:0] div_q;
	logic [32:0] div_r;
	logic [32:0] div_sh;
	logic [31:0] div_res;
	logic [31:0] div_den_sel;

	assign div_sh = {div_r[31:0], div_q[47]};
	assign div_res = (|div_q[47:32]) ? 32'hFFFFFFFF : div_q[31:0];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_busy <= 1'b0;
			div_done <= 1'b0;
			div_cnt <= 6'h00;
			div_q <= 48'h000000000000;
			div_r <= 33'h000000000;
		end else if (ce) begin
			div_done <= 1'b0;
			if (div_start) begin
				div_busy <= 1'b1;
				div_cnt <= ucm_pkg::DIV_STEPS;
				div_q <= div_num;
				div_r <= 33'h000000000;
			end else if (div_busy) begin
				if (div_sh >= {1'b0, div_den}) begin
					div_r <= div_sh - {1'b0, div_den};
					div_q <= {div_q[46:0], 1'b1};
				end else begin
					div_r <= div_sh;
					div_q <= {div_q[46:0], 1'b0};
				end
				div_cnt <= div_cnt - 6'h01;
				if (div_cnt == 6'h01) begin
					div_busy <= 1'b0;
					div_done <= 1'b1;
				end
			end
		end
	end

	// Measurement sequencer
	ucm_pkg::ucm_state_e state;
	logic [31:0] sig_cnt;
	logic [31:0] ref_cnt;
	logic [31:0] hold_cnt;
	logic cap_done;
	logic [1:0] calc_ph;
	logic calc_wait;
	logic [31:0] val;
	logic [31:0] result;
	logic [47:0] acc;
	logic [6:0] avg_n;
	logic done;
	logic avg_act;
	logic need_div;
	logic counting;
	logic [3:0] cfg_arm;

	assign avg_act = act.avg_en && avg_ok;
	assign counting = state == ucm_pkg::UCM_OPEN || state == ucm_pkg::UCM_STOP_WAIT;
	assign cfg_arm = arm_decode(cfg.arm_mode,
		cfg.func inside {ucm_pkg::UCM_PH12, ucm_pkg::UCM_PH21});

	always_comb begin
		need_div = 1'b0;
		div_num = 48'h000000000000;
		unique case (calc_ph)
			2'h0: begin
				need_div = is_phase;
				div_num = {16'h0000, sig_cnt} * ucm_pkg::DEG_PER_CYCLE;
			end
			2'h2: begin
				need_div = 1'b1;
				div_num = acc;
			end
			2'h3: begin
				need_div = act.math_en;
				div_num = {16'h0000, (val > offset) ? val - offset : 32'h00000000};
			end
			default: ;
		endcase
	end

	assign div_start = state == ucm_pkg::UCM_CALC && need_div && !calc_wait && !div_busy;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_den_sel <= 32'h00000000;
		end else if (ce) begin
			unique case (calc_ph)
				2'h0: div_den_sel <= ref_cnt;
				2'h2: div_den_sel <= {25'h0000000, ucm_pkg::AVG_COUNT};
				default: div_den_sel <= scale;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ucm_pkg::UCM_IDLE;
			act <= ucm_pkg::CONFIG_RESET;
			sig_cnt <= 32'h00000000;
			ref_cnt <= 32'h00000000;
			hold_cnt <= 32'h00000000;
			cap_done <= 1'b0;
			calc_ph <= 2'h0;
			calc_wait <= 1'b0;
			val <= 32'h00000000;
			result <= 32'h00000000;
			acc <= 48'h000000000000;
			avg_n <= 7'h00;
			done <= 1'b0;
		end else if (ce) begin
			if (rd_result) begin
				done <= 1'b0;
			end
			if (div_start) begin
				calc_wait <= 1'b1;
			end else if (div_done) begin
				calc_wait <= 1'b0;
			end
			if (counting) begin
				sig_cnt <= sig_cnt + 32'(sig_ev);
				ref_cnt <= ref_cnt + 32'(ref_ev);
				if (is_phase && cap_ev && !cap_done) begin
					sig_cnt <= ref_cnt;
					cap_done <= 1'b1;
				end
			end
			unique case (state)
				ucm_pkg::UCM_IDLE: begin
					if (cmd[ucm_pkg::CMD_ARM_START]) begin
						act <= cfg;
						acc <= 48'h000000000000;
						avg_n <= 7'h00;
						calc_ph <= 2'h0;
						cap_done <= 1'b0;
						sig_cnt <= 32'h00000000;
						ref_cnt <= 32'h00000000;
						state <= cfg_arm[3] ? ucm_pkg::UCM_ARM_WAIT : ucm_pkg::UCM_START_WAIT;
					end else if (cmd[ucm_pkg::CMD_MAN_START] &&
						cfg.func inside {ucm_pkg::UCM_MTOT1, ucm_pkg::UCM_MTOT2}) begin
						act <= cfg;
						calc_ph <= 2'h0;
						state <= ucm_pkg::UCM_OPEN;
					end
				end
				ucm_pkg::UCM_ARM_WAIT: begin
					if (ext_start_ev) begin
						state <= ucm_pkg::UCM_START_WAIT;
					end
				end
				ucm_pkg::UCM_START_WAIT: begin
					if (start_ev) begin
						hold_cnt <= 32'h00000000;
						state <= ucm_pkg::UCM_OPEN;
					end
				end
				ucm_pkg::UCM_OPEN: begin
					if (is_manual) begin
						if (cmd[ucm_pkg::CMD_MAN_STOP]) begin
							state <= ucm_pkg::UCM_CALC;
						end
					end else if (arm[1]) begin
						if (ext_stop_ev) begin
							state <= ucm_pkg::UCM_STOP_WAIT;
						end
					end else if (use_hold || is_phase || act.func inside {ucm_pkg::UCM_PWP,
						ucm_pkg::UCM_PWN}) begin
						if (!use_hold || hold_cnt >= holdoff) begin
							state <= ucm_pkg::UCM_STOP_WAIT;
						end else begin
							hold_cnt <= hold_cnt + 32'h00000001;
						end
					end else if (cmd[ucm_pkg::CMD_ARM_STOP]) begin
						state <= ucm_pkg::UCM_STOP_WAIT;
					end
				end
				ucm_pkg::UCM_STOP_WAIT: begin
					if (stop_ev) begin
						state <= ucm_pkg::UCM_CALC;
					end
				end
				ucm_pkg::UCM_CALC: begin
					unique case (calc_ph)
						2'h0: begin
							if (!is_phase) begin
								val <= primary_ref ? ref_cnt : sig_cnt;
								calc_ph <= 2'h1;
							end else if (div_done) begin
								val <= div_res;
								calc_ph <= 2'h1;
							end
						end
						2'h1: begin
							if (avg_act) begin
								acc <= acc + {16'h0000, val};
								avg_n <= avg_n + 7'h01;
								if (avg_n == ucm_pkg::AVG_COUNT - 7'h01) begin
									calc_ph <= 2'h2;
								end else begin
									sig_cnt <= 32'h00000000;
									ref_cnt <= 32'h00000000;
									calc_ph <= 2'h0;
									state <= ucm_pkg::UCM_START_WAIT;
								end
							end else begin
								calc_ph <= 2'h3;
							end
						end
						2'h2: begin
							if (div_done) begin
								val <= div_res;
								calc_ph <= 2'h3;
							end
						end
						default: begin
							if (!act.math_en || div_done) begin
								result <= act.math_en ? div_res : val;
								done <= 1'b1;
								state <= ucm_pkg::UCM_IDLE;
							end
						end
					endcase
				end
				default: state <= ucm_pkg::UCM_IDLE;
			endcase
			if (cmd[ucm_pkg::CMD_CLEAR] && is_manual) begin
				sig_cnt <= 32'h00000000;
			end
			if (cmd[ucm_pkg::CMD_ABORT]) begin
				state <= ucm_pkg::UCM_IDLE;
				calc_ph <= 2'h0;
			end
		end
	end

	assign div_den = div_den_sel;

	// Gate routing, reference output and event
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ttl_out <= 8'h00;
			ttl_oe <= 8'h00;
			reference_output_port <= 1'b0;
			gate_active <= 1'b0;
		end else if (ce) begin
			ttl_oe <= act.gate_en ? (8'h01 << act.gate_line) : 8'h00;
			ttl_out <= (act.gate_en && counting) ? (8'h01 << act.gate_line) : 8'h00;
			reference_output_port <= ref_sync;
			gate_active <= counting;
		end
	end

	assign meas_event = done;

	// Read port, data valid in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (ce) begin
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				unique case (reg_addr)
					ucm_pkg::OFS_CONFIG: reg_rdata <= {9'h000, cfg};
					ucm_pkg::OFS_STATUS: reg_rdata <= {16'h0000, 1'b0, avg_n, 1'b0, state,
						ext_sig, counting, state != ucm_pkg::UCM_IDLE, done};
					ucm_pkg::OFS_HOLDOFF: reg_rdata <= holdoff;
					ucm_pkg::OFS_OFFSET: reg_rdata <= offset;
					ucm_pkg::OFS_SCALE: reg_rdata <= scale;
					ucm_pkg::OFS_SIG_COUNT: reg_rdata <= sig_cnt;
					ucm_pkg::OFS_REF_COUNT: reg_rdata <= ref_cnt;
					ucm_pkg::OFS_RESULT: reg_rdata <= result;
					ucm_pkg::OFS_TRIG1: reg_rdata <= {14'h0000, trig[0].x10, trig[0].auto_en,
						4'h0, trig[0].level};
					ucm_pkg::OFS_TRIG2: reg_rdata <= {14'h0000, trig[1].x10, trig[1].auto_en,
						4'h0, trig[1].level};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : ucm_measure

`default_nettype wire

// ===== test/ucm_src.sv
`timescale 1ns/1ns
`default_nettype none
module ucm_src (
	input wire logic core_clk,
	input wire logic rst_n,
	output logic [2:0] sig_in,
	output logic ref_clk
);
	logic [5:0] cnt;
	// Inputs never pause, 40 cycle period
	always_ff @(posedge core_clk) begin
		cnt <= (!rst_n || cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
		sig_in <= {cnt >= 6'h10, cnt >= 6'h0A, cnt < 6'h14};
	end
	// 10 MHz reference, off the clock edges
	initial begin
		ref_clk = 1'b0;
		#3;
		forever #50 ref_clk = ~ref_clk;
	end
endmodule : ucm_src
`default_nettype wire

// ===== test/ucm_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ucm_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0] ttl_oe,
	input wire logic [1:0][11:0] trig_level,
	input wire logic [1:0] atten_x10,
	input wire logic meas_event,
	input wire logic gate_active
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_res_rd;
		ce && reg_rd && reg_addr == ucm_pkg::OFS_RESULT;
	endsequence
	sequence s_zero_rd;
		ce && reg_rd && (reg_addr == ucm_pkg::OFS_CMD || reg_addr == 8'hFC);
	endsequence
	sequence s_trig_wr;
		ce && reg_wr && reg_addr == ucm_pkg::OFS_TRIG1 && !reg_wdata[16];
	endsequence
	a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (s_zero_rd |=> reg_rdata == 32'h0)
		else $error("command or unmapped read not zero");
	a_gate_onehot: assert property ($onehot0(ttl_oe))
		else $error("gate driven on several lines");
	a_done_hold: assert property (meas_event && !reg_rd && !reg_wr |=> meas_event)
		else $error("done dropped before read");
	a_read_clear: assert property (meas_event ##0 s_res_rd |=> !meas_event)
		else $error("done not cleared by read");
	a_event_closed: assert property ($rose(meas_event) |-> !gate_active)
		else $error("done while gate open");
	a_level_wr: assert property (s_trig_wr |=> trig_level[0] == $past(reg_wdata[11:0]))
		else $error("manual level not applied");
	a_atten_wr: assert property (s_trig_wr |=> atten_x10[0] == $past(reg_wdata[17]))
		else $error("manual attenuation not applied");
endmodule : ucm_chk
bind ucm_measure ucm_chk chk_u (.core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .ttl_oe, .trig_level, .atten_x10, .meas_event, .gate_active);
`default_nettype wire

// ===== test/tb_ucm_measure.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ucm_measure;
	logic core_clk, rst_n, reg_wr, reg_rd, front_arm_in, ref_clk, meas_event, gate_active;
	logic [7:0] reg_addr, ttl_in, ttl_out, ttl_oe;
	logic [31:0] reg_wdata, reg_rdata, s, r, v;
	logic [2:0] sig_in;
	logic [1:0][11:0] pk_max, pk_min, dc_level, trig_level;
	logic [1:0] atten_x10;
	int errors, compares;
	ucm_pkg::ucm_cfg_s c;
	ucm_src src_u (.core_clk, .rst_n, .sig_in, .ref_clk);
	ucm_measure dut_u (.core_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .sig_in, .front_arm_in, .ttl_in, .ttl_out, .ttl_oe,
		.ref_clk10_bp(ref_clk), .reference_input_port(ref_clk), .ref_osc_int(ref_clk),
		.reference_output_port(), .pk_max, .pk_min, .dc_level, .trig_level, .atten_x10,
		.meas_event, .gate_active);
	task automatic test_done;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask : rd
	// Wait for gate (k=0) or done (k=1) to reach lv
	task automatic wt(input int k, input logic lv);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
			if (n > 3000) begin
				errors++;
				$display("CHECK FAILED t=%0t timeout", $time);
				test_done();
			end
		end while ((k ? meas_event : gate_active) !== lv);
		@(posedge core_clk);
	endtask : wt
	task automatic arm(input logic [31:0] cfg);
		wr(ucm_pkg::OFS_CONFIG, cfg);
		wr(ucm_pkg::OFS_CMD, 32'h1);
	endtask : arm
	task automatic t_reset;
		rd(ucm_pkg::OFS_CONFIG, v);
		chk(v, 32'(ucm_pkg::CONFIG_RESET));
		rd(ucm_pkg::OFS_SCALE, v);
		chk(v, ucm_pkg::SCALE_RESET);
		rd(ucm_pkg::OFS_OFFSET, v);
		chk(v, ucm_pkg::OFFSET_RESET);
		rd(8'hFC, v);
		chk(v, 32'h0);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_freq;
		c = ucm_pkg::CONFIG_RESET;
		c.gate_en = 1'b1;
		c.gate_line = 3'h5;
		arm(32'(c));
		wt(0, 1'b1);
		repeat (3) @(negedge core_clk);
		chk(32'(ttl_oe), 32'h20);
		chk(32'(ttl_out), 32'h20);
		repeat (200) @(posedge core_clk);
		wr(ucm_pkg::OFS_CMD, 32'h2);
		wt(1, 1'b1);
		rd(ucm_pkg::OFS_SIG_COUNT, s);
		rd(ucm_pkg::OFS_REF_COUNT, r);
		chk(32'(s >= 5 && r + 1 >= 8 * s && r <= 8 * s + 1), 32'h1);
		rd(ucm_pkg::OFS_RESULT, v);
		chk(v, s);
		@(negedge core_clk);
		chk(32'(meas_event), 32'h0);
		@(posedge core_clk);
		$display("t_freq done");
	endtask : t_freq
	task automatic t_check;
		c = ucm_pkg::CONFIG_RESET;
		c.func = ucm_pkg::UCM_CHECK;
		c.math_en = 1'b1;
		wr(ucm_pkg::OFS_OFFSET, 32'h3);
		wr(ucm_pkg::OFS_SCALE, 32'h2);
		arm(32'(c));
		wt(0, 1'b1);
		repeat (100) @(posedge core_clk);
		wr(ucm_pkg::OFS_CMD, 32'h2);
		wt(1, 1'b1);
		rd(ucm_pkg::OFS_SIG_COUNT, s);
		rd(ucm_pkg::OFS_REF_COUNT, r);
		chk(s, r);
		rd(ucm_pkg::OFS_RESULT, v);
		chk(v, (s - 32'h3) / 32'h2);
		$display("t_check done");
	endtask : t_check
	// Stop held off past the first input 2 rise: closes 50 cycles after start
	task automatic t_ti;
		c = ucm_pkg::CONFIG_RESET;
		c.func = ucm_pkg::UCM_TI12;
		wr(ucm_pkg::OFS_HOLDOFF, 32'h0000000F);
		arm(32'(c));
		wt(1, 1'b1);
		rd(ucm_pkg::OFS_RESULT, v);
		chk(v, 32'h0000000A);
		$display("t_ti done");
	endtask : t_ti
	task automatic t_ext;
		for (int i = 0; i < 2; i++) begin
			c = ucm_pkg::CONFIG_RESET;
			c.arm_mode = 4'h2;
			c.ext_sel = i ? 4'h8 : 4'h3;
			arm(32'(c));
			repeat (100) @(negedge core_clk);
			chk(32'(gate_active), 32'h0);
			@(posedge core_clk);
			front_arm_in <= (i == 1);
			ttl_in[3] <= (i == 0);
			wt(0, 1'b1);
			wr(ucm_pkg::OFS_CMD, 32'h2);
			wt(1, 1'b1);
			rd(ucm_pkg::OFS_RESULT, v);
			ttl_in <= 8'h00;
			front_arm_in <= 1'b0;
		end
		$display("t_ext done");
	endtask : t_ext
	task automatic pk(input logic [11:0] mx, input logic [11:0] mn, input logic [11:0] dc);
		pk_max[0] <= mx;
		pk_min[0] <= mn;
		dc_level[0] <= dc;
		repeat (8) @(negedge core_clk);
	endtask : pk
	task automatic t_trig;
		wr(ucm_pkg::OFS_TRIG1, 32'h00010000);
		pk(12'h190, 12'h064, 12'h000);
		chk(32'(trig_level[0]), 32'h0FA);
		chk(32'(atten_x10[0]), 32'h0);
		@(posedge core_clk);
		pk(12'h105, 12'h100, 12'h123);
		chk(32'(trig_level[0]), 32'h123);
		@(posedge core_clk);
		pk(12'h7F0, 12'h000, 12'h123);
		chk(32'(atten_x10[0]), 32'h1);
		@(posedge core_clk);
		wr(ucm_pkg::OFS_TRIG1, 32'h00000055);
		$display("t_trig done");
	endtask : t_trig
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		errors = 0;
		compares = 0;
		{rst_n, reg_wr, reg_rd, front_arm_in, reg_addr, ttl_in, reg_wdata} = '0;
		{pk_max, pk_min, dc_level} = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_freq();
		t_check();
		t_ti();
		t_ext();
		t_trig();
		test_done();
	end
endmodule : tb_ucm_measure
`default_nettype wire
